//--- ersp_pkg.sv
// Functional notes
// - clear command edge clears chosen axis error
// - argument zero keeps output inhibition
// - nonzero argument also lifts output inhibition
// - bad axis sets error flag, no execution
// - save command edge writes flash by selector
// - selector zero saves both positioning axes
// - selector one saves counter channel data
// - selector two saves sixteen loop settings
// - save checks axis though value unused
// - emergency stop sets error code, inhibits
// - erase stored set before writing
package ersp_pkg;
  localparam logic [15:0] ERSP_EMG_CODE   = 16'h01e1;
  localparam logic [15:0] ERSP_ERR_NONE   = 16'h0000;
  localparam logic [15:0] ERSP_AXIS_MAX   = 16'h0001;
  localparam logic [15:0] ERSP_SEL_POS    = 16'h0000;
  localparam logic [15:0] ERSP_SEL_CNT    = 16'h0001;
  localparam logic [15:0] ERSP_SEL_LOOP   = 16'h0002;
  localparam int          ERSP_LOOP_COUNT = 16;
  localparam logic [1:0]  ERSP_SYNC_RST   = 2'h0;
  typedef enum logic [1:0] {
    ERSP_DS_POS, ERSP_DS_CNT, ERSP_DS_LOOP, ERSP_DS_NONE
  } ersp_dset_e;
  typedef enum {ERSP_IDLE, ERSP_ERASE, ERSP_WRITE} ersp_st_e;
endpackage

//--- ersp_flash_if.sv
`timescale 1ns/100ps
interface ersp_flash_if;
  logic       start;
  logic [1:0] dset;
  logic       busy;
  logic       erase;
  logic       write;
  modport ctl (output start, output dset, input busy, input erase,
               input write);
  modport seq (input start, input dset, output busy, output erase,
               output write);
endinterface

//--- ersp_flash_seq.sv
`timescale 1ns/100ps
module ersp_flash_seq (
  input wire logic  mclk_i,
  input wire logic  sys_rst_i,
  input wire logic  ce_i,
  input wire logic  flash_done_i,
  ersp_flash_if.seq fl
);
  import ersp_pkg::*;
  ersp_st_e st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ERSP_IDLE:  if (fl.start) nxt_st = ERSP_ERASE;
      // old set goes first so a half write never mixes generations
      ERSP_ERASE: if (flash_done_i) nxt_st = ERSP_WRITE;
      ERSP_WRITE: if (flash_done_i) nxt_st = ERSP_IDLE;
      default:    nxt_st = ERSP_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) st_ff <= ERSP_IDLE;
    else if (ce_i) st_ff <= nxt_st;
  end
  assign fl.busy  = (st_ff != ERSP_IDLE);
  assign fl.erase = (st_ff == ERSP_ERASE);
  assign fl.write = (st_ff == ERSP_WRITE);
  chk_erase_first: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && st_ff == ERSP_IDLE && fl.start) |=> fl.erase)
    else $error("erase did not follow save start");
endmodule

//--- ersp_top.sv
`timescale 1ns/100ps
module ersp_top (
  // clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // commands from the sequence program (same clock)
  input  wire logic        error_clear_command_i,
  input  wire logic        parameter_save_command_i,
  input  wire logic [15:0] axis_select_operand_i,
  input  wire logic [15:0] command_argument_i,
  input  wire logic [15:0] slot_operand_i,
  // emergency stop request, one per axis (same clock)
  input  wire logic [1:0]  emg_stop_i,
  // flash macro
  input  wire logic        flash_done_i,
  output logic             flash_erase_o,
  output logic             flash_write_o,
  output logic [1:0]       flash_dset_o,
  output logic             flash_busy_o,
  // status
  output logic             instruction_error_flag_o,
  output logic [15:0]      axis_x_error_code_o,
  output logic [15:0]      axis_y_error_code_o,
  output logic [1:0]       output_inhibit_o,
  output logic [1:0]       axis_halt_o
);
  import ersp_pkg::*;

  ersp_flash_if fl ();

  ersp_flash_seq u_seq (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .ce_i         (ce_i),
    .flash_done_i (flash_done_i),
    .fl           (fl)
  );

  function automatic logic axis_ok(input logic [15:0] ax);
    axis_ok = (ax <= ERSP_AXIS_MAX);
  endfunction

  logic        clr_q_ff, sav_q_ff;
  logic        err_flag_ff, nxt_err_flag;
  logic [15:0] code_ff [2];
  logic [15:0] nxt_code [2];
  logic [1:0]  inh_ff, nxt_inh;
  logic [1:0]  halt_ff, nxt_halt;
  logic        start_ff, nxt_start;
  logic [1:0]  dset_ff, nxt_dset;
  logic        nxt_fl_erase, nxt_fl_write, nxt_fl_busy;
  logic [1:0]  nxt_fl_dset;
  logic        clr_rise, sav_rise, ax_good;
  logic        ax_idx;

  // slot operand is fixed at zero on this device and carries no function
  assign clr_rise = error_clear_command_i & ~clr_q_ff;
  assign sav_rise = parameter_save_command_i & ~sav_q_ff;
  assign ax_good  = axis_ok(axis_select_operand_i);
  assign ax_idx   = axis_select_operand_i[0];

  always_comb begin
    nxt_err_flag = err_flag_ff;
    nxt_code     = code_ff;
    nxt_inh      = inh_ff;
    nxt_halt     = halt_ff;
    nxt_start    = 1'b0;
    nxt_dset     = dset_ff;
    // flag reflects the most recent command, like a per-instruction flag
    if (clr_rise || sav_rise)
      nxt_err_flag = ~ax_good;
    if (clr_rise && ax_good) begin
      nxt_code[ax_idx] = ERSP_ERR_NONE;
      nxt_halt[ax_idx] = 1'b0;
      if (command_argument_i != 16'h0000)
        nxt_inh[ax_idx] = 1'b0;
      else
        nxt_inh[ax_idx] = inh_ff[ax_idx];
    end
    if (sav_rise && ax_good && !fl.busy) begin
      case (command_argument_i)
        ERSP_SEL_POS:  nxt_dset = ERSP_DS_POS;
        ERSP_SEL_CNT:  nxt_dset = ERSP_DS_CNT;
        ERSP_SEL_LOOP: nxt_dset = ERSP_DS_LOOP;
        default:       nxt_dset = ERSP_DS_NONE;
      endcase
      nxt_start = (command_argument_i <= ERSP_SEL_LOOP);
    end
    // stop arriving with a clear wins: the hazard must stay latched
    for (int i = 0; i < 2; i++) begin
      if (emg_stop_i[i]) begin
        nxt_code[i] = ERSP_EMG_CODE;
        nxt_inh[i]  = 1'b1;
        nxt_halt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      clr_q_ff    <= 1'b0;
      sav_q_ff    <= 1'b0;
      err_flag_ff <= 1'b0;
      code_ff[0]  <= ERSP_ERR_NONE;
      code_ff[1]  <= ERSP_ERR_NONE;
      inh_ff      <= ERSP_SYNC_RST;
      halt_ff     <= ERSP_SYNC_RST;
      start_ff    <= 1'b0;
      dset_ff     <= ERSP_DS_NONE;
    end else if (ce_i) begin
      clr_q_ff    <= error_clear_command_i;
      sav_q_ff    <= parameter_save_command_i;
      err_flag_ff <= nxt_err_flag;
      code_ff     <= nxt_code;
      inh_ff      <= nxt_inh;
      halt_ff     <= nxt_halt;
      start_ff    <= nxt_start;
      dset_ff     <= nxt_dset;
    end
  end

  assign fl.start = start_ff;
  assign fl.dset  = dset_ff;

  // busy already counts the start pulse, so the issuer never sees a gap
  // between an accepted save and the erase phase
  always_comb begin
    nxt_fl_erase = fl.erase;
    nxt_fl_write = fl.write;
    nxt_fl_busy  = fl.busy | start_ff;
    nxt_fl_dset  = dset_ff;
  end

  // registered copies so every output leaves a flip-flop
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_busy_o  <= 1'b0;
      flash_dset_o  <= ERSP_DS_NONE;
    end else if (ce_i) begin
      flash_erase_o <= nxt_fl_erase;
      flash_write_o <= nxt_fl_write;
      flash_busy_o  <= nxt_fl_busy;
      flash_dset_o  <= nxt_fl_dset;
    end
  end

  assign instruction_error_flag_o = err_flag_ff;
  assign axis_x_error_code_o      = code_ff[0];
  assign axis_y_error_code_o      = code_ff[1];
  assign output_inhibit_o         = inh_ff;
  assign axis_halt_o              = halt_ff;

  sequence s_clr_x;
    ce_i && clr_rise && ax_good && !ax_idx && !emg_stop_i[0];
  endsequence
  sequence s_clr_y;
    ce_i && clr_rise && ax_good && ax_idx && !emg_stop_i[1];
  endsequence
  // save accepted: edge, good axis and the flash sequencer idle
  sequence s_save_ok;
    ce_i && sav_rise && ax_good && !fl.busy;
  endsequence

  chk_clr_code: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_clr_x |=> axis_x_error_code_o == ERSP_ERR_NONE)
    else $error("error code not cleared");
  chk_clr_code_y: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_clr_y |=> axis_y_error_code_o == ERSP_ERR_NONE)
    else $error("axis y error code not cleared");
  chk_clr_halt: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_clr_x |=> !axis_halt_o[0])
    else $error("halt not released by clear");
  chk_inh_keep: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_clr_x and command_argument_i == 16'h0000 and output_inhibit_o[0])
      |=> output_inhibit_o[0])
    else $error("inhibit dropped with zero argument");
  chk_inh_lift: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_clr_x and command_argument_i != 16'h0000)
      |=> !output_inhibit_o[0])
    else $error("inhibit not lifted");
  chk_inh_lift_y: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_clr_y and command_argument_i != 16'h0000)
      |=> !output_inhibit_o[1])
    else $error("axis y inhibit not lifted");
  chk_bad_axis: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && (clr_rise || sav_rise) && !ax_good)
      |=> instruction_error_flag_o && !start_ff)
    else $error("bad axis not flagged");
  chk_good_axis: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && (clr_rise || sav_rise) && ax_good)
      |=> !instruction_error_flag_o)
    else $error("error flag set for a valid axis");
  chk_save_go: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_save_ok and command_argument_i <= ERSP_SEL_LOOP)
      |=> start_ff ##1 fl.busy)
    else $error("save did not start");
  chk_save_busy: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && sav_rise && fl.busy) |=> !start_ff && $stable(dset_ff))
    else $error("save accepted while flash busy");
  chk_dset_pos: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_save_ok and command_argument_i == ERSP_SEL_POS)
      |=> dset_ff == ERSP_DS_POS)
    else $error("wrong data set for selector zero");
  chk_dset_cnt: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_save_ok and command_argument_i == ERSP_SEL_CNT)
      |=> dset_ff == ERSP_DS_CNT)
    else $error("wrong data set for selector one");
  chk_dset_loop: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (s_save_ok and command_argument_i == ERSP_SEL_LOOP)
      |=> dset_ff == ERSP_DS_LOOP)
    else $error("wrong data set for selector two");
  chk_save_axis: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && sav_rise && !ax_good) |=> !start_ff)
    else $error("save started with a bad axis");
  chk_sel_over: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && sav_rise && command_argument_i > ERSP_SEL_LOOP)
      |=> !start_ff)
    else $error("flash write for out-of-range selector");
  chk_emg_set: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && emg_stop_i[1]) |=> axis_y_error_code_o == ERSP_EMG_CODE
      && output_inhibit_o[1] && axis_halt_o[1])
    else $error("emergency stop not latched");
  chk_emg_x: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && emg_stop_i[0]) |=> axis_x_error_code_o == ERSP_EMG_CODE
      && output_inhibit_o[0] && axis_halt_o[0])
    else $error("axis x emergency stop not latched");
endmodule

//--- ersp_flash_model.sv
`timescale 1ns/100ps
module ersp_flash_model (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // phase requests from the block, done pulse back
  input  wire logic erase_i,
  input  wire logic write_i,
  output logic      done_o
);
  logic [1:0] cnt_ff;
  // each phase takes a few cycles, so the block must really wait for it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 2'h0;
      done_o <= 1'b0;
    end else begin
      cnt_ff <= ((erase_i | write_i) & ~done_o) ? cnt_ff + 2'h1 : 2'h0;
      done_o <= (erase_i | write_i) & (cnt_ff == 2'h2) & ~done_o;
    end
  end
endmodule

//--- ersp_top_tb.sv
`timescale 1ns/100ps
module ersp_top_tb;
  import ersp_pkg::*;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clr_cmd = 1'b0;
  logic        sav_cmd = 1'b0;
  logic [15:0] axis = 16'h0000;
  logic [15:0] arg = 16'h0000;
  logic [1:0]  emg = 2'h0;
  logic        ce = 1'b1;
  logic        done, erase, write, busy, flag;
  logic [1:0]  dset, inhib, halt;
  logic [15:0] code_x, code_y;
  int          n_errors = 0;
  int          n_compared = 0;
  always #20 mclk_i = ~mclk_i;
  ersp_top u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .error_clear_command_i(clr_cmd), .parameter_save_command_i(sav_cmd),
    .axis_select_operand_i(axis), .command_argument_i(arg),
    .slot_operand_i(16'h0000), .emg_stop_i(emg), .flash_done_i(done),
    .flash_erase_o(erase), .flash_write_o(write), .flash_dset_o(dset),
    .flash_busy_o(busy), .instruction_error_flag_o(flag),
    .axis_x_error_code_o(code_x), .axis_y_error_code_o(code_y),
    .output_inhibit_o(inhib), .axis_halt_o(halt));
  ersp_flash_model u_flash (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .erase_i(erase), .write_i(write), .done_o(done));
  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // bounded wait; running out ends the run as a failure
  task automatic wait_lvl(input string what, ref logic sig, input logic lvl);
    for (int i = 0; i < 20 && sig !== lvl; i++) cyc(1);
    check(what, sig, lvl);
    if (sig !== lvl) complete_run();
  endtask
  task automatic issue(input logic save, input logic [15:0] ax, a);
    axis = ax;
    arg = a;
    if (save) sav_cmd = 1'b1;
    else clr_cmd = 1'b1;
    cyc(2);
    clr_cmd = 1'b0;
    sav_cmd = 1'b0;
    cyc(1);
  endtask
  task automatic stop_axis(input logic [1:0] which);
    emg = which;
    cyc(1);
    emg = 2'h0;
    cyc(2);
  endtask
  task automatic t_clear_keep();
    stop_axis(2'h1);
    check("code_x", code_x, ERSP_EMG_CODE);
    check("halt", {14'h0, halt}, 16'h0001);
    issue(1'b0, 16'h0000, 16'h0000);
    check("code_x", code_x, ERSP_ERR_NONE);
    check("inhib", {14'h0, inhib}, 16'h0001);
    check("halt", {14'h0, halt}, 16'h0000);
  endtask
  task automatic t_clear_lift();
    stop_axis(2'h2);
    issue(1'b0, 16'h0001, 16'hffff);
    check("code_y", code_y, ERSP_ERR_NONE);
    check("inhib", {14'h0, inhib}, 16'h0001);
    check("halt", {14'h0, halt}, 16'h0000);
  endtask
  task automatic t_bad_axis();
    issue(1'b0, 16'h0002, 16'h0001);
    check("flag", flag, 1'b1);
    check("inhib", {14'h0, inhib}, 16'h0001);
    issue(1'b0, 16'h0000, 16'h0001);
    check("flag", flag, 1'b0);
    issue(1'b1, 16'hffff, ERSP_SEL_POS);
    cyc(5);
    check("flag", flag, 1'b1);
    check("erase", erase, 1'b0);
  endtask
  // erase must come first, then the write of the same data set
  task automatic t_save(input logic [15:0] sel);
    issue(1'b1, sel & 16'h0001, sel);
    wait_lvl("erase", erase, 1'b1);
    check("dset", dset, sel);
    check("write", write, 1'b0);
    check("flag", flag, 1'b0);
    wait_lvl("erase", erase, 1'b0);
    wait_lvl("write", write, 1'b1);
    check("dset", dset, sel);
    wait_lvl("busy", busy, 1'b0);
    check("write", write, 1'b0);
  endtask
  task automatic t_save_none();
    issue(1'b1, 16'h0000, 16'h0003);
    cyc(6);
    check("busy", busy, 1'b0);
    check("erase", erase, 1'b0);
  endtask
  // a second save while the first still runs is dropped silently
  task automatic t_save_busy();
    issue(1'b1, 16'h0000, ERSP_SEL_POS);
    wait_lvl("erase", erase, 1'b1);
    issue(1'b1, 16'h0000, ERSP_SEL_LOOP);
    check("dset", dset, ERSP_SEL_POS);
    wait_lvl("busy", busy, 1'b0);
    cyc(4);
    check("erase", erase, 1'b0);
    check("dset", dset, ERSP_SEL_POS);
  endtask
  // with the enable low nothing may move, stops and commands alike
  task automatic t_freeze();
    ce = 1'b0;
    emg = 2'h3;
    axis = 16'h0002;
    clr_cmd = 1'b1;
    sav_cmd = 1'b1;
    cyc(3);
    emg = 2'h0;
    clr_cmd = 1'b0;
    sav_cmd = 1'b0;
    cyc(1);
    ce = 1'b1;
    cyc(3);
    check("code_x", code_x, ERSP_ERR_NONE);
    check("code_y", code_y, ERSP_ERR_NONE);
    check("inhib", {14'h0, inhib}, 16'h0000);
    check("flag", flag, 1'b0);
    check("busy", busy, 1'b0);
  endtask
  initial begin
    cyc(3);
    sys_rst_i = 1'b0;
    check("dset", dset, 2'h3);
    check("code_x", code_x, ERSP_ERR_NONE);
    t_clear_keep();
    t_clear_lift();
    t_bad_axis();
    t_save(ERSP_SEL_POS);
    t_save(ERSP_SEL_CNT);
    t_save(ERSP_SEL_LOOP);
    t_save_none();
    t_save_busy();
    t_freeze();
    complete_run();
  end
endmodule
